// ===== hdl/exec_pkg.sv
// Shared types and constants for the arithmetic and branch execution block.
// Assumes a single core clock domain and a synchronous active-high reset.
package exec_pkg;

    // ****************************************
    // Widths and working-register set
    // ****************************************
    localparam int WORD_W = 16;
    localparam int NUM_WORK_REGS = 16;
    localparam logic [3:0] ACCUM_REG_IDX = 4'h0;
    localparam logic [3:0] SQUARE_REG_LO = 4'h4;
    localparam logic [3:0] SQUARE_REG_HI = 4'h7;
    localparam logic [9:0] BYTE_IMM_MAX = 10'h0ff;
    localparam logic [15:0] WORK_REG_RST = 16'h0000;
    localparam logic [4:0] FLAGS_RST = 5'h00;

    // ****************************************
    // Status flag positions
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_Z = 4;

    // ****************************************
    // Operations, sizes, operand sources, states
    // ****************************************
    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_SUM_WITH_CARRY = 4'h1,
        OP_AND = 4'h2,
        OP_SHIFT_ONE = 4'h3,
        OP_SHIFT_MULTI = 4'h4,
        OP_BIT_ZEROING = 4'h5,
        OP_BRANCH_CARRY = 4'h6,
        OP_BRANCH_GE = 4'h7,
        OP_BRANCH_GEU = 4'h8,
        OP_SQUARE = 4'h9
    } op_t;

    typedef enum logic [1:0] {
        SIZE_WORD = 2'h0,
        SIZE_BYTE = 2'h1,
        SIZE_DOUBLE = 2'h2
    } size_t;

    typedef enum logic [2:0] {
        SRC_REGS = 3'h0,
        SRC_SHORT = 3'h1,
        SRC_MEDIUM = 3'h2,
        SRC_SIGNED_MEDIUM = 3'h3,
        SRC_FILE = 3'h4
    } src_kind_t;

    typedef enum logic [0:0] {
        ST_ISSUE = 1'b0,
        ST_BUBBLE = 1'b1
    } state_t;

endpackage

// ===== hdl/alu_if.sv
// Operand and result bundle between the execution top and its ALU.
// Purely combinational; the top owns all registers.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    exec_pkg::op_t op;
    exec_pkg::size_t size;
    logic [15:0] opnd_a;
    logic [15:0] opnd_b;
    logic carry_in;
    logic [3:0] bit_sel;
    logic [15:0] res;
    logic [4:0] flags;

    modport ctrl (output op, size, opnd_a, opnd_b, carry_in, bit_sel, input res, flags);
    modport alu (input op, size, opnd_a, opnd_b, carry_in, bit_sel, output res, flags);
endinterface
`default_nettype wire

// ===== hdl/work_reg_file.sv
// Sixteen working registers, one write port and three read ports.
// Reads are combinational; the caller registers anything leaving the block.
`timescale 1ns/1ps
`default_nettype none
module work_reg_file (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] rd_a_idx,
    input wire logic [3:0] rd_b_idx,
    input wire logic [3:0] rd_c_idx,
    output logic [15:0] rd_a,
    output logic [15:0] rd_b,
    output logic [15:0] rd_c
);
    logic [15:0] regs_q [exec_pkg::NUM_WORK_REGS];
    logic [15:0] regs_d [exec_pkg::NUM_WORK_REGS];

    // Next values: only the addressed register changes
    always_comb begin
        for (int i = 0; i < exec_pkg::NUM_WORK_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (wr_en) begin
            regs_d[wr_idx] = wr_data;
        end
    end

    // Storage
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < exec_pkg::NUM_WORK_REGS; i++) begin
            regs_q[i] <= rst ? exec_pkg::WORK_REG_RST : regs_d[i];
        end
    end

    // Read ports
    assign rd_a = regs_q[rd_a_idx];
    assign rd_b = regs_q[rd_b_idx];
    assign rd_c = regs_q[rd_c_idx];
endmodule
`default_nettype wire

// ===== hdl/alu_core.sv
// Combinational ALU: add, add with carry, AND, shifts, bit zeroing, square.
// Flags are raw; the top decides which ones are kept and applies sticky zero.
`timescale 1ns/1ps
`default_nettype none
module alu_core (
    alu_if.alu bus
);
    logic [16:0] sum_w;
    logic [8:0] sum_b;
    logic [4:0] sum_n;
    logic [31:0] prod;
    logic byte_mode;
    logic sign_a;
    logic sign_b;
    logic sign_r;

    // Arithmetic for every operation, size picked by byte_mode
    always_comb begin
        byte_mode = (bus.size == exec_pkg::SIZE_BYTE);
        sum_w = {1'b0, bus.opnd_a} + {1'b0, bus.opnd_b} + {16'h0000, bus.carry_in};
        sum_b = {1'b0, bus.opnd_a[7:0]} + {1'b0, bus.opnd_b[7:0]} + {8'h00, bus.carry_in};
        sum_n = {1'b0, bus.opnd_a[3:0]} + {1'b0, bus.opnd_b[3:0]} + {4'h0, bus.carry_in};
        prod = bus.opnd_a * bus.opnd_a;
        bus.res = 16'h0000;
        bus.flags = 5'h00;
        case (bus.op)
            exec_pkg::OP_ADD, exec_pkg::OP_SUM_WITH_CARRY: begin
                bus.res = byte_mode ? {8'h00, sum_b[7:0]} : sum_w[15:0];
                bus.flags[exec_pkg::FLAG_C] = byte_mode ? sum_b[8] : sum_w[16];
                // Nibble carry from bit 3 in byte mode, bit 7 in word mode
                bus.flags[exec_pkg::FLAG_DC] = byte_mode ? sum_n[4] : sum_b[8];
            end
            exec_pkg::OP_AND: begin
                bus.res = bus.opnd_a & bus.opnd_b;
            end
            exec_pkg::OP_SHIFT_ONE: begin
                bus.res = byte_mode ? {8'h00, bus.opnd_a[7], bus.opnd_a[7:1]}
                                    : {bus.opnd_a[15], bus.opnd_a[15:1]};
                bus.flags[exec_pkg::FLAG_C] = bus.opnd_a[0];
            end
            exec_pkg::OP_SHIFT_MULTI: begin
                bus.res = byte_mode ? {8'h00, 8'($signed(bus.opnd_a[7:0]) >>> bus.opnd_b[3:0])}
                                    : 16'($signed(bus.opnd_a) >>> bus.opnd_b[3:0]);
            end
            exec_pkg::OP_BIT_ZEROING: begin
                bus.res = bus.opnd_a & ~(16'h0001 << bus.bit_sel);
            end
            exec_pkg::OP_SQUARE: begin
                bus.res = prod[15:0];
            end
            default: begin
                bus.res = 16'h0000;
            end
        endcase
        if (byte_mode) begin
            bus.res = {8'h00, bus.res[7:0]};
        end
        sign_a = byte_mode ? bus.opnd_a[7] : bus.opnd_a[15];
        sign_b = byte_mode ? bus.opnd_b[7] : bus.opnd_b[15];
        sign_r = byte_mode ? bus.res[7] : bus.res[15];
        bus.flags[exec_pkg::FLAG_N] = sign_r;
        bus.flags[exec_pkg::FLAG_Z] = byte_mode ? (bus.res[7:0] == 8'h00) : (bus.res == 16'h0000);
        // Signed overflow only means something for the adders
        bus.flags[exec_pkg::FLAG_OV] = (bus.op == exec_pkg::OP_ADD
                                        || bus.op == exec_pkg::OP_SUM_WITH_CARRY)
                                       && (sign_a == sign_b) && (sign_r != sign_a);
    end
endmodule
`default_nettype wire

// ===== hdl/cpu_arith_branch_exec.sv
// Execution datapath for add, add with carry, AND, arithmetic shifts, bit
// zeroing, square and three conditional branches, with working registers and
// the status flags. Assumes an instruction decoder drives one issue at a time
// on the core clock and that data memory sits outside (file operand port).
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_branch_exec (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire exec_pkg::op_t op_sel,
    input wire exec_pkg::size_t size_sel,
    input wire exec_pkg::src_kind_t src_kind,
    input wire logic dest_to_file,
    input wire logic [3:0] base_work_reg,
    input wire logic [3:0] source_work_reg,
    input wire logic [3:0] dest_work_reg,
    input wire logic [4:0] short_immediate,
    input wire logic [9:0] medium_immediate,
    input wire logic [9:0] signed_medium_immediate,
    input wire logic [3:0] bit_position_field,
    input wire logic [22:0] program_addr_immediate,
    input wire logic [15:0] file_data,
    input wire logic [3:0] peek_sel,
    output logic issue_ready_q,
    output logic result_valid_q,
    output logic [15:0] result_q,
    output logic file_wr_q,
    output logic reject_q,
    output logic branch_taken_q,
    output logic [22:0] branch_target_q,
    output logic [4:0] status_q,
    output logic [15:0] peek_data_q
);

    // ****************************************
    // Declarations
    // ****************************************
    alu_if alu_bus ();
    exec_pkg::state_t state_q;
    exec_pkg::state_t state_d;
    logic issue_ready_d;
    logic result_valid_d;
    logic [15:0] result_d;
    logic file_wr_d;
    logic reject_d;
    logic branch_taken_d;
    logic [22:0] branch_target_d;
    logic [4:0] status_d;
    logic [15:0] peek_data_d;
    logic accept;
    logic is_branch;
    logic cond_true;
    logic illegal;
    logic [4:0] keep_mask;
    logic reg_wr_en;
    logic [3:0] reg_wr_idx;
    logic [15:0] reg_wr_data;
    logic [3:0] rd_a_idx;
    logic [3:0] rd_b_idx;
    logic [15:0] rd_a;
    logic [15:0] rd_b;
    logic [15:0] rd_peek;
    logic [15:0] old_dest;
    logic [3:0] dest_idx;
    logic file_form;
    logic [4:0] flags_new;

    // ****************************************
    // Working registers and ALU
    // ****************************************
    work_reg_file u_regs (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(reg_wr_en),
        .wr_idx(reg_wr_idx),
        .wr_data(reg_wr_data),
        .rd_a_idx(rd_a_idx),
        .rd_b_idx(rd_b_idx),
        .rd_c_idx(peek_sel),
        .rd_a(rd_a),
        .rd_b(rd_b),
        .rd_c(rd_peek)
    );

    alu_core u_alu (
        .bus(alu_bus.alu)
    );

    // ****************************************
    // Operand selection
    // ****************************************
    // Read port A carries the first source, port B the second or old dest
    always_comb begin
        accept = issue_valid && issue_ready_q;
        file_form = (src_kind == exec_pkg::SRC_FILE);
        is_branch = (op_sel == exec_pkg::OP_BRANCH_CARRY) || (op_sel == exec_pkg::OP_BRANCH_GE)
                    || (op_sel == exec_pkg::OP_BRANCH_GEU);
        // File forms read the accumulator, register zero, and write it unless dest_to_file sends the result to the file
        dest_idx = file_form ? exec_pkg::ACCUM_REG_IDX : dest_work_reg;
        rd_a_idx = base_work_reg;
        rd_b_idx = source_work_reg;
        alu_bus.opnd_a = rd_a;
        alu_bus.opnd_b = rd_b;
        case (src_kind)
            exec_pkg::SRC_FILE: begin
                rd_b_idx = exec_pkg::ACCUM_REG_IDX;
                alu_bus.opnd_a = file_data;
            end
            exec_pkg::SRC_SHORT: begin
                alu_bus.opnd_b = {11'h000, short_immediate};
            end
            exec_pkg::SRC_MEDIUM: begin
                // Literal form: Wn is both second operand and destination
                rd_b_idx = dest_work_reg;
                alu_bus.opnd_a = {6'h00, medium_immediate};
                alu_bus.opnd_b = rd_b;
            end
            exec_pkg::SRC_SIGNED_MEDIUM: begin
                rd_b_idx = dest_work_reg;
                alu_bus.opnd_a = {{6{signed_medium_immediate[9]}},
                                  signed_medium_immediate};
                alu_bus.opnd_b = rd_b;
            end
            default: begin
                alu_bus.opnd_b = rd_b;
            end
        endcase
        // Two-operand forms take their only source from the source register
        if ((op_sel == exec_pkg::OP_SHIFT_ONE || op_sel == exec_pkg::OP_BIT_ZEROING
             || op_sel == exec_pkg::OP_SQUARE) && !file_form) begin
            rd_a_idx = source_work_reg;
        end
        alu_bus.op = op_sel;
        alu_bus.size = size_sel;
        alu_bus.carry_in = status_q[exec_pkg::FLAG_C]
                           && (op_sel == exec_pkg::OP_SUM_WITH_CARRY);
        // Byte targets only have eight bits to pick from
        alu_bus.bit_sel = (size_sel == exec_pkg::SIZE_BYTE) ? {1'b0, bit_position_field[2:0]}
                                                           : bit_position_field;
    end

    // ****************************************
    // Legality and branch conditions
    // ****************************************
    // A refused issue writes nothing and leaves the flags alone
    always_comb begin
        illegal = 1'b0;
        // Double-word size has no meaning for this subset
        if (size_sel == exec_pkg::SIZE_DOUBLE) begin
            illegal = 1'b1;
        end
        if (src_kind == exec_pkg::SRC_MEDIUM && size_sel == exec_pkg::SIZE_BYTE
            && medium_immediate > exec_pkg::BYTE_IMM_MAX) begin
            illegal = 1'b1;
        end
        if (op_sel == exec_pkg::OP_SQUARE && (file_form
            || source_work_reg < exec_pkg::SQUARE_REG_LO
            || source_work_reg > exec_pkg::SQUARE_REG_HI)) begin
            illegal = 1'b1;
        end
        if (is_branch && program_addr_immediate[0]) begin
            illegal = 1'b1;
        end
        case (op_sel)
            exec_pkg::OP_BRANCH_CARRY: begin
                cond_true = status_q[exec_pkg::FLAG_C];
            end
            exec_pkg::OP_BRANCH_GE: begin
                cond_true = status_q[exec_pkg::FLAG_N] == status_q[exec_pkg::FLAG_OV];
            end
            exec_pkg::OP_BRANCH_GEU: begin
                cond_true = status_q[exec_pkg::FLAG_C];
            end
            default: begin
                cond_true = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Flag update masks
    // ****************************************
    // One bit per flag that the operation is allowed to change
    always_comb begin
        case (op_sel)
            exec_pkg::OP_ADD: begin
                keep_mask = 5'h1f;
            end
            exec_pkg::OP_SUM_WITH_CARRY: begin
                keep_mask = 5'h1f;
            end
            exec_pkg::OP_AND: begin
                keep_mask = 5'h14;
            end
            exec_pkg::OP_SHIFT_ONE: begin
                keep_mask = 5'h1d;
            end
            exec_pkg::OP_SHIFT_MULTI: begin
                keep_mask = 5'h14;
            end
            default: begin
                keep_mask = 5'h00;
            end
        endcase
        flags_new = alu_bus.flags;
        // Zero is sticky for add with carry: a zero result keeps the old Z
        if (op_sel == exec_pkg::OP_SUM_WITH_CARRY && alu_bus.flags[exec_pkg::FLAG_Z]) begin
            flags_new[exec_pkg::FLAG_Z] = status_q[exec_pkg::FLAG_Z];
        end
    end

    // ****************************************
    // Issue control and write-back
    // ****************************************
    // Taken branch spends a second cycle as a bubble; all else is one cycle
    always_comb begin
        state_d = exec_pkg::ST_ISSUE;
        issue_ready_d = 1'b1;
        result_valid_d = 1'b0;
        result_d = result_q;
        file_wr_d = 1'b0;
        reject_d = 1'b0;
        branch_taken_d = 1'b0;
        branch_target_d = branch_target_q;
        status_d = status_q;
        reg_wr_en = 1'b0;
        reg_wr_idx = dest_idx;
        old_dest = rd_b;
        reg_wr_data = alu_bus.res;
        case (state_q)
            exec_pkg::ST_ISSUE: begin
                if (accept && illegal) begin
                    reject_d = 1'b1;
                end else if (accept && is_branch) begin
                    if (cond_true) begin
                        branch_taken_d = 1'b1;
                        branch_target_d = program_addr_immediate;
                        state_d = exec_pkg::ST_BUBBLE;
                        issue_ready_d = 1'b0;
                    end
                end else if (accept) begin
                    result_valid_d = 1'b1;
                    result_d = alu_bus.res;
                    status_d = (status_q & ~keep_mask) | (flags_new & keep_mask);
                    // Byte results take the upper byte from the source register, or from the destination in literal and file forms
                    if (size_sel == exec_pkg::SIZE_BYTE) begin
                        old_dest = (file_form && dest_to_file) ? file_data : rd_b;
                        reg_wr_data = {old_dest[15:8], alu_bus.res[7:0]};
                        result_d = reg_wr_data;
                    end
                    if (file_form && dest_to_file) begin
                        file_wr_d = 1'b1;
                    end else begin
                        reg_wr_en = 1'b1;
                    end
                end
            end
            exec_pkg::ST_BUBBLE: begin
                state_d = exec_pkg::ST_ISSUE;
            end
            default: begin
                state_d = exec_pkg::ST_ISSUE;
            end
        endcase
        peek_data_d = rd_peek;
    end

    // Registers for control, status and every output
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= exec_pkg::ST_ISSUE;
            issue_ready_q <= 1'b1;
            result_valid_q <= 1'b0;
            result_q <= 16'h0000;
            file_wr_q <= 1'b0;
            reject_q <= 1'b0;
            branch_taken_q <= 1'b0;
            branch_target_q <= 23'h000000;
            status_q <= exec_pkg::FLAGS_RST;
            peek_data_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            issue_ready_q <= issue_ready_d;
            result_valid_q <= result_valid_d;
            result_q <= result_d;
            file_wr_q <= file_wr_d;
            reject_q <= reject_d;
            branch_taken_q <= branch_taken_d;
            branch_target_q <= branch_target_d;
            status_q <= status_d;
            peek_data_q <= peek_data_d;
        end
    end

endmodule
`default_nettype wire

// ===== tb/exec_properties.sv
// Port checker for the execution block: refusals, branch timing, flag scope.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module exec_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire exec_pkg::op_t op_sel,
    input wire exec_pkg::size_t size_sel,
    input wire logic [22:0] program_addr_immediate,
    input wire logic issue_ready_q,
    input wire logic result_valid_q,
    input wire logic reject_q,
    input wire logic branch_taken_q,
    input wire logic [22:0] branch_target_q,
    input wire logic [4:0] status_q
);
    // ****************************************
    // Accepted issues
    // ****************************************
    logic take;
    logic word;
    logic br;
    // An issue only counts while ready is high
    assign take = issue_valid && issue_ready_q;
    assign word = take && size_sel == exec_pkg::SIZE_WORD;
    assign br = take && op_sel inside {exec_pkg::OP_BRANCH_CARRY, exec_pkg::OP_BRANCH_GE,
        exec_pkg::OP_BRANCH_GEU};

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_double_refused: assert property (
        take && size_sel == exec_pkg::SIZE_DOUBLE |=> reject_q && $stable(status_q))
        else $error("double size not refused");
    a_odd_target: assert property (
        br && program_addr_immediate[0] |=> reject_q && !branch_taken_q)
        else $error("odd target not refused");
    a_target_even: assert property (
        branch_taken_q |-> !branch_target_q[0])
        else $error("odd target taken");
    a_branch_stall: assert property (
        branch_taken_q |-> !issue_ready_q ##1 issue_ready_q)
        else $error("taken branch not two cycles");
    a_branch_flags: assert property (
        br |=> $stable(status_q))
        else $error("branch changed flags");
    a_add_one_cycle: assert property (
        word && op_sel == exec_pkg::OP_ADD |=> result_valid_q)
        else $error("add not done in one cycle");
    a_zeroing_flags: assert property (
        take && op_sel == exec_pkg::OP_BIT_ZEROING |=> $stable(status_q))
        else $error("bit zeroing changed flags");
    a_and_flags: assert property (
        word && op_sel == exec_pkg::OP_AND |=> status_q[1:0] == $past(status_q[1:0])
        && status_q[3] == $past(status_q[3]))
        else $error("and touched carry or overflow");
    a_multi_flags: assert property (
        word && op_sel == exec_pkg::OP_SHIFT_MULTI |=> status_q[1:0] == $past(status_q[1:0])
        && status_q[3] == $past(status_q[3]))
        else $error("multi shift touched carry or overflow");
endmodule

bind cpu_arith_branch_exec exec_properties chk (.core_clk, .rst, .issue_valid, .op_sel,
    .size_sel, .program_addr_immediate, .issue_ready_q, .result_valid_q, .reject_q,
    .branch_taken_q, .branch_target_q, .status_q);
`default_nettype wire

// ===== tb/test_cpu_arith_branch_exec.sv
// Self-checking bench for the execution block, one task per scenario.
// Inputs change 1 ns after the rising edge; the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); \
    end \
end
module test_cpu_arith_branch_exec;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic issue_valid = 1'h0;
    logic dest_to_file = 1'h0;
    exec_pkg::op_t op_sel = exec_pkg::OP_ADD;
    exec_pkg::size_t size_sel = exec_pkg::SIZE_WORD;
    exec_pkg::src_kind_t src_kind = exec_pkg::SRC_REGS;
    logic [3:0] base_work_reg = 4'h0;
    logic [3:0] source_work_reg = 4'h0;
    logic [3:0] dest_work_reg = 4'h0;
    logic [3:0] bit_position_field = 4'h0;
    logic [3:0] peek_sel = 4'h0;
    logic [4:0] short_immediate = 5'h00;
    logic [9:0] medium_immediate = 10'h000;
    logic [9:0] signed_medium_immediate = 10'h000;
    logic [22:0] program_addr_immediate = 23'h000000;
    logic [15:0] file_data = 16'h0000;
    logic issue_ready_q;
    logic result_valid_q;
    logic file_wr_q;
    logic reject_q;
    logic branch_taken_q;
    logic [15:0] result_q;
    logic [15:0] peek_data_q;
    logic [22:0] branch_target_q;
    logic [4:0] status_q;
    int miscompares = 0;
    int checked = 0;

    cpu_arith_branch_exec dut (.core_clk, .rst, .issue_valid, .op_sel, .size_sel, .src_kind,
        .dest_to_file, .base_work_reg, .source_work_reg, .dest_work_reg, .short_immediate,
        .medium_immediate, .signed_medium_immediate, .bit_position_field,
        .program_addr_immediate, .file_data, .peek_sel, .issue_ready_q, .result_valid_q,
        .result_q, .file_wr_q, .reject_q, .branch_taken_q, .branch_target_q, .status_q,
        .peek_data_q);

    // Free-running core clock, 50 ns period
    always #25 core_clk = ~core_clk;

    // ****************************************
    // Shared drivers
    // ****************************************
    // Holds issue_valid up so operations run back to back
    task automatic go(input exec_pkg::op_t o, input logic [3:0] b, input logic [3:0] s,
            input logic [3:0] d, input logic [9:0] i);
        op_sel = o;
        base_work_reg = b;
        source_work_reg = s;
        dest_work_reg = d;
        medium_immediate = i;
        signed_medium_immediate = i;
        short_immediate = i[4:0];
        bit_position_field = i[3:0];
        issue_valid = 1'h1;
        @(posedge core_clk);
        #1;
    endtask
    task automatic rest();
        issue_valid = 1'h0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic res(input logic [15:0] r, input logic [4:0] st);
        `CHK(result_valid_q, 1'h1)
        `CHK(result_q, r)
        `CHK(status_q, st)
    endtask
    // Peek output lags the selection by one edge
    task automatic peek(input logic [3:0] i, input logic [15:0] v);
        peek_sel = i;
        @(posedge core_clk);
        #1;
        `CHK(peek_data_q, v)
    endtask
    task automatic branch(input exec_pkg::op_t o, input logic [22:0] t, input logic tk,
            input logic [4:0] st);
        program_addr_immediate = t;
        go(o, 4'h0, 4'h0, 4'h0, 10'h000);
        `CHK(branch_taken_q, tk)
        `CHK(issue_ready_q, !tk)
        `CHK(status_q, st)
        if (tk) `CHK(branch_target_q, t)
        rest();
        `CHK(issue_ready_q, 1'h1)
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_reset();
        `CHK(issue_ready_q, 1'h1)
        `CHK(status_q, 5'h00)
        peek(4'h9, 16'h0000);
    endtask
    task automatic s_load();
        src_kind = exec_pkg::SRC_MEDIUM;
        go(exec_pkg::OP_ADD, 4'h0, 4'h0, 4'h1, 10'h001);
        res(16'h0001, 5'h00);
        src_kind = exec_pkg::SRC_SIGNED_MEDIUM;
        go(exec_pkg::OP_ADD, 4'h0, 4'h0, 4'h5, 10'h3ff);
        res(16'hffff, 5'h04);
        rest();
        src_kind = exec_pkg::SRC_REGS;
        branch(exec_pkg::OP_BRANCH_GE, 23'h000100, 1'h0, 5'h04);
    endtask
    task automatic s_arith();
        go(exec_pkg::OP_ADD, 4'h5, 4'h1, 4'h3, 10'h000);
        res(16'h0000, 5'h13);
        go(exec_pkg::OP_SUM_WITH_CARRY, 4'h1, 4'h4, 4'h4, 10'h000);
        res(16'h0002, 5'h00);
        go(exec_pkg::OP_SUM_WITH_CARRY, 4'h5, 4'h1, 4'h6, 10'h000);
        res(16'h0000, 5'h03);
    endtask
    task automatic s_logic();
        go(exec_pkg::OP_AND, 4'h5, 4'h4, 4'h7, 10'h000);
        res(16'h0002, 5'h03);
        go(exec_pkg::OP_SHIFT_ONE, 4'h0, 4'h5, 4'h8, 10'h000);
        res(16'hffff, 5'h07);
        src_kind = exec_pkg::SRC_SHORT;
        go(exec_pkg::OP_SHIFT_MULTI, 4'h7, 4'h0, 4'hf, 10'h001);
        res(16'h0001, 5'h03);
        src_kind = exec_pkg::SRC_REGS;
        go(exec_pkg::OP_BIT_ZEROING, 4'h0, 4'h8, 4'h8, 10'h00f);
        res(16'h7fff, 5'h03);
        rest();
        peek(4'hf, 16'h0001);
        peek(4'h8, 16'h7fff);
    endtask
    task automatic s_square();
        go(exec_pkg::OP_SQUARE, 4'h0, 4'h4, 4'ha, 10'h000);
        res(16'h0004, 5'h03);
        go(exec_pkg::OP_SQUARE, 4'h0, 4'h3, 4'ha, 10'h000);
        `CHK(reject_q, 1'h1)
        `CHK(result_valid_q, 1'h0)
        rest();
    endtask
    task automatic s_branch_taken();
        branch(exec_pkg::OP_BRANCH_GE, 23'h000100, 1'h1, 5'h03);
        branch(exec_pkg::OP_BRANCH_GEU, 23'h000200, 1'h1, 5'h03);
        branch(exec_pkg::OP_BRANCH_CARRY, 23'h000300, 1'h1, 5'h03);
        program_addr_immediate = 23'h000101;
        go(exec_pkg::OP_BRANCH_GEU, 4'h0, 4'h0, 4'h0, 10'h000);
        `CHK(reject_q, 1'h1)
        `CHK(branch_taken_q, 1'h0)
        rest();
    endtask
    // Accumulator form: result lands in register zero or goes out to the file
    task automatic s_file();
        src_kind = exec_pkg::SRC_FILE;
        file_data = 16'h1234;
        go(exec_pkg::OP_ADD, 4'h0, 4'h0, 4'h0, 10'h000);
        res(16'h1234, 5'h00);
        `CHK(file_wr_q, 1'h0)
        file_data = 16'h0001;
        dest_to_file = 1'h1;
        go(exec_pkg::OP_ADD, 4'h0, 4'h0, 4'h0, 10'h000);
        res(16'h1235, 5'h00);
        `CHK(file_wr_q, 1'h1)
        rest();
        dest_to_file = 1'h0;
        peek(4'h0, 16'h1234);
    endtask
    task automatic s_sizes();
        src_kind = exec_pkg::SRC_MEDIUM;
        size_sel = exec_pkg::SIZE_BYTE;
        go(exec_pkg::OP_ADD, 4'h0, 4'h0, 4'h1, 10'h100);
        `CHK(reject_q, 1'h1)
        go(exec_pkg::OP_ADD, 4'h0, 4'h0, 4'h1, 10'h0ff);
        res(16'h0000, 5'h13);
        src_kind = exec_pkg::SRC_REGS;
        size_sel = exec_pkg::SIZE_DOUBLE;
        go(exec_pkg::OP_ADD, 4'h1, 4'h1, 4'h2, 10'h000);
        `CHK(reject_q, 1'h1)
        src_kind = exec_pkg::SRC_SHORT;
        size_sel = exec_pkg::SIZE_WORD;
        go(exec_pkg::OP_ADD, 4'h1, 4'h0, 4'hb, 10'h01f);
        res(16'h001f, 5'h00);
        rest();
        branch(exec_pkg::OP_BRANCH_GEU, 23'h000400, 1'h0, 5'h00);
    endtask

    // ****************************************
    // Sequence, verdict and watchdog
    // ****************************************
    task automatic complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'h0;
        s_reset();
        s_load();
        s_arith();
        s_logic();
        s_square();
        s_branch_taken();
        s_file();
        s_sizes();
        complete_run();
    end
    // Whole sequence needs well under 100 cycles
    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule
`undef CHK
`default_nettype wire
